// ---- bxd_direction_ctrl.sv ----
// Direction and state control of one bus extender unit
`timescale 1ns/10ps
// What this block does
// - Local state here always pairs with matching remote state in the twin unit
// - Two modes, controller-capable and talk-only, chosen by a static switch
// - Switches open give controller-capable mode and buffered poll replies
// - Controller mode resolves IFC first, then ATN, then DAV
// - After reset in controller-capable mode no state is active until IFC appears on a side
// - Local IFC sets local system controller; IFC and REN go to twin
// - Local ATN sets local active controller; ATN out, SRQ in
// - Local DAV sets local source; DAV and data out, NRFD and NDAC in
// - When the source side changes, states and directions follow
// - Talk-only keeps controller states off, IFC REN ATN SRQ unused
// - Talk-only fixes directions at the first DAV
// - Poll reply handling buffered or unbuffered by static switch
// - Buffered mode answers identify within 200 ns from the stored buffer
// - Buffered mode also forwards the poll and returns the remote reply
// - Buffer loads the remote reply when local identify ends
// - Unbuffered mode passes identify through and returns reply directly
// - Twins may use different poll modes if controllers share a side
// - Power-on reset clears every state flip-flop
// - While a local poll is relayed, local NRFD is held asserted
// - After controller found and before source, NDAC true and NRFD false
module bxd_direction_ctrl (
    input  wire logic              clk,
    input  wire logic              sys_rst,        // Power-on reset pulse, held until both units are up
    input  wire logic              modeSwitch,     // 1: talk-only mode
    input  wire logic              ppSwitch,       // 1: unbuffered poll replies
    input  wire bxd_pkg::bxd_bus_s localIn,        // Levels seen on the local GPIB, active high
    input  wire bxd_pkg::bxd_bus_s linkIn,         // Levels received from the twin unit
    input  wire bxd_pkg::bxd_state_s twinLocal,    // Local states reported by the twin
    input  wire logic              twinPollDone,   // Twin has the remote poll reply ready
    output bxd_pkg::bxd_bus_s      localOut,       // Levels driven on the local GPIB
    output bxd_pkg::bxd_bus_s      localOe,        // Per-line drive enables, local GPIB
    output bxd_pkg::bxd_bus_s      linkOut,        // Levels sent to the twin
    output bxd_pkg::bxd_bus_s      linkOe,         // Per-line drive enables toward the twin
    output bxd_pkg::bxd_state_s    localState,     // Own local states, sent to the twin
    output bxd_pkg::bxd_state_s    remoteState,    // Own remote states
    output logic                   pollDone        // Remote poll answered, reported to twin
);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    bxd_pkg::bxd_bus_s   locS1_q, locS2_q, lnkS1_q, lnkS2_q;
    bxd_pkg::bxd_state_s twS1_q, twS2_q;
    logic [3:0]          cfgS1_q, cfgS2_q;

    // Every outside level passes two flops before use
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            locS1_q <= '0;
            locS2_q <= '0;
            lnkS1_q <= '0;
            lnkS2_q <= '0;
            twS1_q  <= '0;
            twS2_q  <= '0;
            cfgS1_q <= '0;
            cfgS2_q <= '0;
        end else begin
            locS1_q <= localIn;
            locS2_q <= locS1_q;
            lnkS1_q <= linkIn;
            lnkS2_q <= lnkS1_q;
            twS1_q  <= twinLocal;
            twS2_q  <= twS1_q;
            cfgS1_q <= {twinPollDone, 1'h0, ppSwitch, modeSwitch};
            cfgS2_q <= cfgS1_q;
        end
    end

    logic talkOnly;
    logic unbuffered;
    logic twinDone;
    assign talkOnly   = (cfgS2_q[0] != bxd_pkg::MODE_CTRL_CAPABLE);
    assign unbuffered = (cfgS2_q[1] != bxd_pkg::PP_BUFFERED);
    assign twinDone   = cfgS2_q[3];

    // Previous levels for edge detection
    logic ifcPrev_q, atnPrev_q, davPrev_q;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ifcPrev_q <= 1'h0;
            atnPrev_q <= 1'h0;
            davPrev_q <= 1'h0;
        end else begin
            ifcPrev_q <= locS2_q.ifc;
            atnPrev_q <= locS2_q.atn;
            davPrev_q <= locS2_q.dav;
        end
    end

    logic ifcRise, atnRise, davRise, atnEdge;
    assign ifcRise = locS2_q.ifc & ~ifcPrev_q;
    assign atnRise = locS2_q.atn & ~atnPrev_q;
    assign davRise = locS2_q.dav & ~davPrev_q;
    assign atnEdge = locS2_q.atn ^ atnPrev_q;

    // ************************************************************
    // Local and remote state flip-flops
    // ************************************************************
    bxd_pkg::bxd_state_s loc_q, rem_q;
    bxd_pkg::bxd_pp_e    pp_q;
    logic                ctlFound;
    logic                pollActive;
    logic                remPoll;
    assign ctlFound   = talkOnly | loc_q.actCtl | rem_q.actCtl;
    assign pollActive = (pp_q != bxd_pkg::PP_IDLE);
    assign remPoll    = rem_q.actCtl & lnkS2_q.atn & lnkS2_q.eoi;

    // System controller: local edge wins, twin's claim moves us remote
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            loc_q.sysCtl <= 1'h0;
            rem_q.sysCtl <= 1'h0;
        end else if (talkOnly) begin
            loc_q.sysCtl <= 1'h0;
            rem_q.sysCtl <= 1'h0;
        end else if (ifcRise) begin
            loc_q.sysCtl <= 1'h1;
            rem_q.sysCtl <= 1'h0;
        end else if (twS2_q.sysCtl) begin
            loc_q.sysCtl <= 1'h0;
            rem_q.sysCtl <= 1'h1;
        end
    end

    // Active controller: only once a system controller is located
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            loc_q.actCtl <= 1'h0;
            rem_q.actCtl <= 1'h0;
        end else if (talkOnly || !(loc_q.sysCtl || rem_q.sysCtl)) begin
            loc_q.actCtl <= 1'h0;
            rem_q.actCtl <= 1'h0;
        end else if (atnRise && !rem_q.actCtl) begin
            loc_q.actCtl <= 1'h1;
        end else if (twS2_q.actCtl) begin
            loc_q.actCtl <= 1'h0;
            rem_q.actCtl <= 1'h1;
        end
    end

    // Source: cleared on ATN change outside talk-only, local poll or remote poll; ordered after controller
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            loc_q.source <= 1'h0;
            rem_q.source <= 1'h0;
        end else if (!ctlFound || (!talkOnly && atnEdge) || pollActive || remPoll) begin
            loc_q.source <= 1'h0;
            rem_q.source <= 1'h0;
        end else if (talkOnly && (loc_q.source || rem_q.source)) begin
            loc_q.source <= loc_q.source;                            // direction fixed
            rem_q.source <= rem_q.source;
        end else if (davRise && !lnkS2_q.dav && !rem_q.source) begin
            loc_q.source <= 1'h1;
        end else if (twS2_q.source && !locS2_q.dav) begin
            loc_q.source <= 1'h0;
            rem_q.source <= 1'h1;
        end
    end

    // ************************************************************
    // Parallel poll sequencing and reply buffer
    // ************************************************************
    logic idy;
    logic [7:0] ppr_q;
    assign idy = locS2_q.atn & locS2_q.eoi & loc_q.actCtl;

    // Hold poll toward twin until reply back and local identify over
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pp_q <= bxd_pkg::PP_IDLE;
        end else begin
            case (pp_q)
                bxd_pkg::PP_IDLE: begin
                    if (idy) begin
                        pp_q <= bxd_pkg::PP_WAIT;
                    end
                end
                bxd_pkg::PP_WAIT: begin
                    if (twinDone && !idy) begin
                        pp_q <= bxd_pkg::PP_DONE;
                    end
                end
                bxd_pkg::PP_DONE: begin
                    if (!twinDone) begin
                        pp_q <= bxd_pkg::PP_IDLE;
                    end
                end
                default: pp_q <= bxd_pkg::PP_IDLE;
            endcase
        end
    end

    // Latch remote reply as identify ends; buffer reflects the previous poll
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ppr_q <= bxd_pkg::PPR_RESET;
        end else if (pp_q == bxd_pkg::PP_WAIT && twinDone && !idy) begin
            ppr_q <= lnkS2_q.dio;
        end
    end

    // Remote poll: wait the settle time, then report the reply ready
    logic [$clog2(bxd_pkg::PP_HOLD_CYC + 1) - 1:0] ppCnt_q;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ppCnt_q <= '0;
        end else if (!remPoll) begin
            ppCnt_q <= '0;
        end else if (ppCnt_q != bxd_pkg::PP_HOLD_CYC[$bits(ppCnt_q) - 1:0]) begin
            ppCnt_q <= ppCnt_q + 1'h1;
        end
    end

    // ************************************************************
    // Output steering, all registered
    // ************************************************************
    bxd_pkg::bxd_bus_s lo_d, loe_d, xo_d, xoe_d;
    always_comb begin
        lo_d  = '0;
        loe_d = '0;
        xo_d  = '0;
        xoe_d = '0;
        // IFC and REN flow from the system controller's side
        xo_d.ifc  = locS2_q.ifc;
        xo_d.ren  = locS2_q.ren;
        xoe_d.ifc = loc_q.sysCtl;
        xoe_d.ren = loc_q.sysCtl;
        lo_d.ifc  = lnkS2_q.ifc;
        lo_d.ren  = lnkS2_q.ren;
        loe_d.ifc = rem_q.sysCtl;
        loe_d.ren = rem_q.sysCtl;
        // ATN out, SRQ back; poll keeps ATN and EOI asserted until answered
        xo_d.atn  = locS2_q.atn | (pp_q == bxd_pkg::PP_WAIT);
        xo_d.eoi  = (pp_q == bxd_pkg::PP_WAIT) | (loc_q.source & locS2_q.eoi);
        xoe_d.atn = loc_q.actCtl;
        xoe_d.eoi = loc_q.actCtl | loc_q.source;
        lo_d.srq  = lnkS2_q.srq;
        loe_d.srq = loc_q.actCtl;
        xo_d.srq  = locS2_q.srq;
        xoe_d.srq = rem_q.actCtl;
        lo_d.atn  = lnkS2_q.atn;
        lo_d.eoi  = lnkS2_q.eoi;
        loe_d.atn = rem_q.actCtl;
        loe_d.eoi = rem_q.actCtl | rem_q.source;
        // Handshake: source side sends DAV and data, receives NRFD and NDAC
        xo_d.dav  = locS2_q.dav;
        xoe_d.dav = loc_q.source;
        lo_d.dav  = lnkS2_q.dav;
        loe_d.dav = rem_q.source;
        xo_d.nrfd = locS2_q.nrfd;
        xo_d.ndac = locS2_q.ndac;
        xoe_d.nrfd = rem_q.source;
        xoe_d.ndac = rem_q.source;
        if (pollActive) begin
            lo_d.nrfd  = 1'h1;
            loe_d.nrfd = 1'h1;
        end else if (loc_q.source) begin
            lo_d.nrfd  = lnkS2_q.nrfd;
            lo_d.ndac  = lnkS2_q.ndac;
            loe_d.nrfd = 1'h1;
            loe_d.ndac = 1'h1;
        end else if (ctlFound) begin
            lo_d.ndac  = 1'h1;                                       // NRFD left passive
            loe_d.ndac = 1'h1;
        end
        // Local data: poll reply while polled, else remote source data
        if (pp_q == bxd_pkg::PP_WAIT && !unbuffered) begin
            lo_d.dio  = ppr_q;
            loe_d.dio = 8'hff;
        end else if (pollActive || (rem_q.source && !remPoll)) begin
            lo_d.dio  = lnkS2_q.dio;
            loe_d.dio = 8'hff;
        end
        // Link data: remote poll reply or own source data
        xo_d.dio = locS2_q.dio;
        if (remPoll || (loc_q.source && !pollActive)) begin
            xoe_d.dio = 8'hff;
        end
        // Remote poll is replayed onto this unit's bus
        if (remPoll) begin
            lo_d.atn  = 1'h1;
            lo_d.eoi  = 1'h1;
            loe_d.eoi = 1'h1;
        end
    end

    // Register every output
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            localOut    <= '0;
            localOe     <= '0;
            linkOut     <= '0;
            linkOe      <= '0;
            localState  <= '0;
            remoteState <= '0;
            pollDone    <= 1'h0;
        end else begin
            localOut    <= lo_d;
            localOe     <= loe_d;
            linkOut     <= xo_d;
            linkOe      <= xoe_d;
            localState  <= loc_q;
            remoteState <= rem_q;
            pollDone    <= (ppCnt_q == bxd_pkg::PP_HOLD_CYC[$bits(ppCnt_q) - 1:0]);
        end
    end

endmodule

// ---- bxd_pkg.sv ----
// Package for the bus extender direction control block: types and constants
package bxd_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS   = 50;
    localparam int IDY_REPLY_NS    = 200;                 // Longest time to answer identify
    localparam int IDY_REPLY_CYC   = (IDY_REPLY_NS / CLK_PERIOD_NS < 1) ? 1 : IDY_REPLY_NS / CLK_PERIOD_NS;
    localparam int PP_HOLD_NS      = 2000;                // Remote poll settle time
    localparam int PP_HOLD_CYC     = (PP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ************************************************************
    // Reset values and switch encodings
    // ************************************************************
    localparam logic MODE_CTRL_CAPABLE = 1'h0;             // Switch open selects controller-capable
    localparam logic PP_BUFFERED       = 1'h0;             // Switch open selects buffered replies
    localparam logic [7:0] PPR_RESET   = 8'h00;

    // Parallel poll sequencing
    typedef enum logic [2:0] {
        PP_IDLE = 3'b001,
        PP_WAIT = 3'b010,
        PP_DONE = 3'b100
    } bxd_pp_e;

    // Lines of one GPIB side
    typedef struct packed {
        logic       ifc;
        logic       ren;
        logic       atn;
        logic       srq;
        logic       eoi;
        logic       dav;
        logic       nrfd;
        logic       ndac;
        logic [7:0] dio;
    } bxd_bus_s;

    // Local/remote states
    typedef struct packed {
        logic sysCtl;
        logic actCtl;
        logic source;
    } bxd_state_s;

endpackage

// ---- bxd_properties.sv ----
// Port-level assertions for the extender direction control
`timescale 1ns/10ps
module bxd_properties (
    input wire logic                clk,
    input wire logic                sys_rst,
    input wire logic                modeSwitch,
    input wire logic                ppSwitch,
    input wire bxd_pkg::bxd_bus_s   localIn,
    input wire bxd_pkg::bxd_state_s twinLocal,
    input wire bxd_pkg::bxd_bus_s   localOut,
    input wire bxd_pkg::bxd_bus_s   localOe,
    input wire bxd_pkg::bxd_bus_s   linkOe,
    input wire bxd_pkg::bxd_state_s localState,
    input wire bxd_pkg::bxd_state_s remoteState,
    input wire logic                pollDone
);
    // ****************************
    // Properties
    // ****************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Identify starts while this side is the active controller
    sequence idyStart;
        $rose(localIn.atn && localIn.eoi) && localState.actCtl && !ppSwitch;
    endsequence
    // Stored reply on the data lines, then NRFD holdoff
    sequence replyShown;
        localOe.dio == 8'hff ##1 localOut.nrfd;
    endsequence
    reset_quiet_a: assert property ($fell(sys_rst) |-> !localState && !remoteState && !pollDone)
        else $error("state active after reset");
    ifc_claim_a: assert property ($rose(localIn.ifc) && !modeSwitch && !twinLocal.sysCtl |-> ##[2:6] localState.sysCtl)
        else $error("local IFC not claimed");
    ifc_route_a: assert property (localState.sysCtl && $past(localState.sysCtl) |-> linkOe.ifc && linkOe.ren)
        else $error("IFC or REN not sent to twin");
    atn_order_a: assert property ($rose(localState.actCtl) |-> localState.sysCtl || remoteState.sysCtl)
        else $error("controller found before system controller");
    atn_route_a: assert property (localState.actCtl && $past(localState.actCtl) |-> linkOe.atn && !linkOe.srq)
        else $error("ATN or SRQ direction wrong");
    pair_excl_a: assert property ((localState & remoteState) == 3'h0)
        else $error("same state both local and remote");
    talk_quiet_a: assert property (modeSwitch |-> !localState.sysCtl && !localState.actCtl && !remoteState.actCtl)
        else $error("controller state in talk-only");
    src_route_a: assert property (localState.source && $past(localState.source) |-> linkOe.dav)
        else $error("DAV not sent to twin");
    rsrc_route_a: assert property (remoteState.source && $past(remoteState.source) |-> localOe.dav && !linkOe.dav)
        else $error("DAV not driven locally");
    buf_reply_a: assert property (idyStart |-> ##[1:4] replyShown)
        else $error("stored reply late");
endmodule

bind bxd_direction_ctrl bxd_properties i_bxd_properties (.clk(clk), .sys_rst(sys_rst), .modeSwitch(modeSwitch),
    .ppSwitch(ppSwitch), .localIn(localIn), .twinLocal(twinLocal), .localOut(localOut), .localOe(localOe),
    .linkOe(linkOe), .localState(localState), .remoteState(remoteState), .pollDone(pollDone));

// ---- bxd_twin_model.sv ----
// Behavioural model of the twin extender across the link
`timescale 1ns/10ps
module bxd_twin_model (
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire bxd_pkg::bxd_bus_s   linkOut,
    input  wire bxd_pkg::bxd_bus_s   linkOe,
    input  wire bxd_pkg::bxd_state_s claim,        // Twin local states set by the bench
    input  wire bxd_pkg::bxd_bus_s   farBus,       // Levels on the far bus
    input  wire logic [7:0]          reply,        // Far bus poll reply
    output bxd_pkg::bxd_bus_s        linkIn,
    output bxd_pkg::bxd_state_s      twinLocal,
    output logic                     twinPollDone
);
    // ****************************
    // Far side
    // ****************************
    int unsigned holdCnt;
    // Far identify held 2 us before the reply counts; released data lines toggle so stale data never matches
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            holdCnt      <= 0;
            twinPollDone <= 1'b0;
            linkIn       <= '0;
            twinLocal    <= '0;
        end else begin
            twinLocal <= claim;
            linkIn    <= farBus;
            if (linkOut.atn && linkOut.eoi && linkOe.atn && linkOe.eoi) begin
                holdCnt      <= holdCnt + 1;
                twinPollDone <= holdCnt >= bxd_pkg::PP_HOLD_CYC - 1;
            end else begin
                holdCnt      <= 0;
                twinPollDone <= 1'b0;
            end
            if (twinPollDone) linkIn.dio <= reply;
            else if (claim.source) linkIn.dio <= farBus.dio;
            else linkIn.dio <= ~linkIn.dio;
        end
    end
endmodule

// ---- tb_top.sv ----
// Self-checking testbench for the extender direction control
`timescale 1ns/10ps
module tb_top;
    logic                clk, sys_rst, modeSwitch, ppSwitch, twinPollDone, pollDone;
    bxd_pkg::bxd_bus_s   localIn, farBus, linkIn, localOut, localOe, linkOut, linkOe;
    bxd_pkg::bxd_state_s claim, twinLocal, localState, remoteState;
    logic [7:0]          reply;
    int                  failures, n_tests;

    bxd_direction_ctrl i_bxd_direction_ctrl (.clk(clk), .sys_rst(sys_rst), .modeSwitch(modeSwitch),
        .ppSwitch(ppSwitch), .localIn(localIn), .linkIn(linkIn), .twinLocal(twinLocal),
        .twinPollDone(twinPollDone), .localOut(localOut), .localOe(localOe), .linkOut(linkOut),
        .linkOe(linkOe), .localState(localState), .remoteState(remoteState), .pollDone(pollDone));
    bxd_twin_model i_bxd_twin_model (.clk(clk), .sys_rst(sys_rst), .linkOut(linkOut), .linkOe(linkOe),
        .claim(claim), .farBus(farBus), .reply(reply), .linkIn(linkIn), .twinLocal(twinLocal),
        .twinPollDone(twinPollDone));

    // ****************************
    // Helpers
    // ****************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (failures == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Switches change only under reset since they are static straps
    task automatic restart(input logic mode, input logic pp);
        sys_rst    = 1'b1;
        modeSwitch = mode;
        ppSwitch   = pp;
        localIn    = '0;
        claim      = '0;
        farBus     = '0;
        cyc(4);
        sys_rst    = 1'b0;
        cyc(1);
    endtask
    // IFC pulse, then ATN held; five cycles cover sync plus output latency
    task automatic findCtrl();
        localIn.ifc = 1'b1;
        cyc(2);
        localIn.ifc = 1'b0;
        cyc(5);
        localIn.atn = 1'b1;
        cyc(5);
    endtask
    // One identify; bounded waits on the twin reply, a hang ends the run
    task automatic poll(input logic buffered, input logic [7:0] expDio);
        int k;
        localIn.eoi = 1'b1;
        cyc(4);
        if (buffered) check(16'({localOe.dio, localOut.dio}), {8'hff, expDio});
        cyc(1);
        check(16'({localOut.nrfd, linkOut.atn, linkOut.eoi}), 16'h7);
        for (k = 0; k < 80 && !twinPollDone; k++) cyc(1); // identify held until the reply is back
        if (!twinPollDone) begin
            failures++;
            finish_test();
        end
        cyc(5);
        if (!buffered) check(16'({localOe.dio, localOut.dio}), {8'hff, expDio});
        localIn.eoi = 1'b0;
        for (k = 0; k < 80 && twinPollDone; k++) cyc(1);
        if (twinPollDone) begin
            failures++;
            finish_test();
        end
        cyc(6);
    endtask

    // ****************************
    // Scenarios
    // ****************************
    initial begin
        failures = 0;
        n_tests  = 0;
        reply    = 8'h3c;
        restart(bxd_pkg::MODE_CTRL_CAPABLE, bxd_pkg::PP_BUFFERED);
        check(16'({localState, remoteState, pollDone}), 16'h0);
        localIn.atn = 1'b1;
        cyc(5);
        check(16'(localState), 16'h0);
        localIn.atn = 1'b0;
        cyc(5);
        findCtrl();
        check(16'({localState, remoteState}), 16'h30);
        check(16'({linkOe.ifc, linkOe.ren, linkOe.atn}), 16'h7);
        check(16'({localOut.ndac, localOe.ndac, localOut.nrfd}), 16'h6);
        localIn.dio = 8'ha5;
        localIn.dav = 1'b1;
        cyc(5);
        check(16'({localState.source, linkOe.dav, linkOut.dav, linkOut.dio}), 16'h7a5);
        localIn.dav = 1'b0;
        claim.source = 1'b1;
        farBus.dav = 1'b1;
        farBus.dio = 8'h5a;
        cyc(6);
        check(16'({localState.source, remoteState.source, localOut.dav, localOut.dio}), 16'h35a);
        claim.source = 1'b0;
        farBus.dav = 1'b0;
        cyc(6);
        poll(1'b1, bxd_pkg::PPR_RESET);
        reply = 8'h81;
        poll(1'b1, 8'h3c);
        poll(1'b1, 8'h81);
        claim.sysCtl = 1'b1;
        cyc(6);
        check(16'({localState.sysCtl, remoteState.sysCtl, localOe.ifc, localOe.ren}), 16'h7);
        // Remote identify is replayed here; pollDone must still be low 20 cycles in and high 28 cycles later
        claim.actCtl = 1'b1;
        farBus.atn = 1'b1;
        farBus.eoi = 1'b1;
        cyc(20);
        check(16'({remoteState.actCtl, localOe.eoi, linkOe.dio, pollDone}), 16'h7fe);
        cyc(28);
        check(16'({pollDone, localOut.atn, localOut.eoi, localOe.eoi}), 16'hf);
        // Unbuffered replies pass straight through
        restart(bxd_pkg::MODE_CTRL_CAPABLE, 1'b1);
        findCtrl();
        reply = 8'h96;
        poll(1'b0, 8'h96);
        // Talk-only: controllers stay off, first DAV fixes direction
        restart(1'b1, bxd_pkg::PP_BUFFERED);
        findCtrl();
        check(16'({localState, remoteState, linkOe.ifc, linkOe.atn}), 16'h0);
        localIn.atn = 1'b0;
        localIn.dav = 1'b1;
        cyc(5);
        check(16'(localState), 16'h1);
        localIn.dav = 1'b0;
        claim.source = 1'b1;
        farBus.dav = 1'b1;
        cyc(6);
        check(16'({localState, remoteState}), 16'h8);
        finish_test();
    end
endmodule
